// ===== logic/ssi_pkg.sv
// Package with register map, field positions, reset values and carrier types of the serial port.
package ssi_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [5:0] IDX_CTRL1 = 6'h13;
   localparam logic [5:0] IDX_CTRL2 = 6'h14;
   localparam logic [5:0] IDX_CTRL3 = 6'h15;
   localparam logic [5:0] IDX_STATUS = 6'h16;
   localparam logic [5:0] IDX_DATA = 6'h18;

   // Character format register.
   localparam int CTRL1_CHAR9 = 4;

   // Interrupt enable and transfer enable register.
   localparam int CTRL2_TXE_IE = 7;
   localparam int CTRL2_TC_IE = 6;
   localparam int CTRL2_RXF_IE = 5;
   localparam int CTRL2_IDLE_IE = 4;
   localparam int CTRL2_TX_EN = 3;
   localparam int CTRL2_RX_EN = 2;

   // Ninth bit and error interrupt enable register.
   localparam int CTRL3_R8 = 7;
   localparam int CTRL3_T8 = 6;
   localparam int CTRL3_OVR_IE = 3;
   localparam int CTRL3_NF_IE = 2;
   localparam int CTRL3_FE_IE = 1;
   localparam int CTRL3_PE_IE = 0;

   // Status flag register.
   localparam int ST_TXE = 7;
   localparam int ST_TC = 6;
   localparam int ST_RXF = 5;
   localparam int ST_IDLE = 4;
   localparam int ST_OVR = 3;
   localparam int ST_NF = 2;
   localparam int ST_FE = 1;
   localparam int ST_PE = 0;

   // Reset values.
   localparam logic RST_TXE = 1'b1;
   localparam logic RST_TC = 1'b1;
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_CTRL_BIT = 1'b0;
   localparam logic [7:0] RST_SNAP = 8'h00;

   // Idle line run length in bit times for 8-bit and 9-bit characters.
   localparam logic [3:0] IDLE_ONES_8 = 4'ha;
   localparam logic [3:0] IDLE_ONES_9 = 4'hb;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [8:0] data;
      logic noise;
      logic framing;
      logic parity;
   } ssi_rx_char_t;

   typedef struct packed {
      logic tx;
      logic rx;
      logic err;
   } ssi_irq_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACCEPT = 2'h1,
      BUS_RESP = 2'h3
   } ssi_bus_st_t;

endpackage : ssi_pkg

// ===== logic/ssi_idle_det.sv
// Idle line detector that counts consecutive high bit times on the receive input.
`timescale 1ns/1ps
module ssi_idle_det (
   // Clock and control
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic en,
   input wire logic char9,
   // Receive line samples
   input wire logic bit_tick,
   input wire logic line,
   // Detection
   output logic det
);
   logic [3:0] cnt_q;
   logic [3:0] thr;

   assign thr = char9 ? ssi_pkg::IDLE_ONES_9 : ssi_pkg::IDLE_ONES_8;

   // The count saturates at the threshold so one idle run gives one pulse.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q <= 4'h0;
         det <= 1'b0;
      end else if (ce) begin
         det <= 1'b0;
         if (!en || (bit_tick && !line)) begin
            cnt_q <= 4'h0;
         end else if (bit_tick && cnt_q != thr) begin
            cnt_q <= cnt_q + 4'h1;
            det <= (cnt_q == thr - 4'h1);
         end
      end
   end
endmodule : ssi_idle_det

// ===== logic/ssi_top.sv
// Status flags, ninth bit handling and interrupt requests of the serial port.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ssi_top (
   // Clock, reset and clock enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // AXI4-Lite write channels
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read channels
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Receive shift register side
   input wire logic rx_char_done,
   input wire ssi_pkg::ssi_rx_char_t rx_char,
   input wire logic rx_bit_tick,
   input wire logic rx_line,
   // Transmit shift register side
   input wire logic tx_take,
   input wire logic tx_busy,
   input wire logic tx_queue,
   output logic [8:0] tx_word_q,
   output logic tx_empty_q,
   // Configuration to the shift registers
   output logic char9_q,
   output logic tx_en_q,
   output logic rx_en_q,
   // Interrupt requests
   output ssi_pkg::ssi_irq_t irq_q
);
   ssi_pkg::ssi_bus_st_t wr_st_q;
   ssi_pkg::ssi_bus_st_t rd_st_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic txe_ie_q;
   logic tc_ie_q;
   logic rxf_ie_q;
   logic idle_ie_q;
   logic t8_q;
   logic [3:0] err_ie_q;
   logic tc_q;
   logic rxf_q;
   logic idle_q;
   logic ovr_q;
   logic nf_q;
   logic fe_q;
   logic pe_q;
   logic idle_arm_q;
   logic [7:0] snap_q;
   logic [7:0] rdr_q;
   logic [7:0] tdr_q;
   logic r8_q;

   logic [7:0] status;
   logic [7:0] ctrl3;
   logic [7:0] rd_mux;
   logic wr_en;
   logic rd_en;
   logic wr_ok;
   logic wr_ctrl1;
   logic wr_ctrl2;
   logic wr_ctrl3;
   logic wr_data;
   logic rd_status;
   logic rd_data;
   logic rx_load;
   logic rx_ovr;
   logic idle_det;

   function automatic logic mapped(input logic [31:0] a);
      logic [5:0] idx;
      idx = a[7:2];
      mapped = (a[31:8] == 24'h0) && (idx == ssi_pkg::IDX_CTRL1 ||
         idx == ssi_pkg::IDX_CTRL2 || idx == ssi_pkg::IDX_CTRL3 ||
         idx == ssi_pkg::IDX_STATUS || idx == ssi_pkg::IDX_DATA);
   endfunction : mapped

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Register accesses take effect at the handshake edge of the accept state.
   assign wr_en = ce && wr_st_q == ssi_pkg::BUS_ACCEPT;
   assign rd_en = ce && rd_st_q == ssi_pkg::BUS_ACCEPT;
   assign wr_ok = wr_en && mapped(s_axi_awaddr) && s_axi_wstrb[0];
   assign wr_ctrl1 = wr_ok && s_axi_awaddr[7:2] == ssi_pkg::IDX_CTRL1;
   assign wr_ctrl2 = wr_ok && s_axi_awaddr[7:2] == ssi_pkg::IDX_CTRL2;
   assign wr_ctrl3 = wr_ok && s_axi_awaddr[7:2] == ssi_pkg::IDX_CTRL3;
   assign wr_data = wr_ok && s_axi_awaddr[7:2] == ssi_pkg::IDX_DATA;
   assign rd_status = rd_en && mapped(s_axi_araddr) &&
      s_axi_araddr[7:2] == ssi_pkg::IDX_STATUS;
   assign rd_data = rd_en && mapped(s_axi_araddr) && s_axi_araddr[7:2] == ssi_pkg::IDX_DATA;

   // A character arriving while the last one is unread is dropped.
   assign rx_load = rx_char_done && !rxf_q;
   assign rx_ovr = rx_char_done && rxf_q;

   always_comb begin
      status = 8'h00;
      status[ssi_pkg::ST_TXE] = tx_empty_q;
      status[ssi_pkg::ST_TC] = tc_q;
      status[ssi_pkg::ST_RXF] = rxf_q;
      status[ssi_pkg::ST_IDLE] = idle_q;
      status[ssi_pkg::ST_OVR] = ovr_q;
      status[ssi_pkg::ST_NF] = nf_q;
      status[ssi_pkg::ST_FE] = fe_q;
      status[ssi_pkg::ST_PE] = pe_q;
      ctrl3 = 8'h00;
      ctrl3[ssi_pkg::CTRL3_R8] = r8_q;
      ctrl3[ssi_pkg::CTRL3_T8] = t8_q;
      ctrl3[ssi_pkg::CTRL3_OVR_IE:ssi_pkg::CTRL3_PE_IE] = err_ie_q;
   end

   always_comb begin
      rd_mux = 8'h00;
      case (s_axi_araddr[7:2])
         ssi_pkg::IDX_CTRL1: rd_mux[ssi_pkg::CTRL1_CHAR9] = char9_q;
         ssi_pkg::IDX_CTRL2: begin
            rd_mux[ssi_pkg::CTRL2_TXE_IE] = txe_ie_q;
            rd_mux[ssi_pkg::CTRL2_TC_IE] = tc_ie_q;
            rd_mux[ssi_pkg::CTRL2_RXF_IE] = rxf_ie_q;
            rd_mux[ssi_pkg::CTRL2_IDLE_IE] = idle_ie_q;
            rd_mux[ssi_pkg::CTRL2_TX_EN] = tx_en_q;
            rd_mux[ssi_pkg::CTRL2_RX_EN] = rx_en_q;
         end
         ssi_pkg::IDX_CTRL3: rd_mux = ctrl3;
         ssi_pkg::IDX_STATUS: rd_mux = status;
         ssi_pkg::IDX_DATA: rd_mux = rdr_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Write path waits for address and data together, then answers one cycle later.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_st_q <= ssi_pkg::BUS_IDLE;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= ssi_pkg::RESP_OKAY;
      end else if (ce) begin
         case (wr_st_q)
            ssi_pkg::BUS_IDLE: if (s_axi_awvalid && s_axi_wvalid) begin
               awready_q <= 1'b1;
               wready_q <= 1'b1;
               wr_st_q <= ssi_pkg::BUS_ACCEPT;
            end
            ssi_pkg::BUS_ACCEPT: begin
               awready_q <= 1'b0;
               wready_q <= 1'b0;
               bvalid_q <= 1'b1;
               bresp_q <= mapped(s_axi_awaddr) ? ssi_pkg::RESP_OKAY : ssi_pkg::RESP_SLVERR;
               wr_st_q <= ssi_pkg::BUS_RESP;
            end
            ssi_pkg::BUS_RESP: if (s_axi_bready) begin
               bvalid_q <= 1'b0;
               wr_st_q <= ssi_pkg::BUS_IDLE;
            end
            default: wr_st_q <= ssi_pkg::BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_st_q <= ssi_pkg::BUS_IDLE;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= ssi_pkg::RESP_OKAY;
      end else if (ce) begin
         case (rd_st_q)
            ssi_pkg::BUS_IDLE: if (s_axi_arvalid) begin
               arready_q <= 1'b1;
               rd_st_q <= ssi_pkg::BUS_ACCEPT;
            end
            ssi_pkg::BUS_ACCEPT: begin
               arready_q <= 1'b0;
               rvalid_q <= 1'b1;
               rdata_q <= {24'h0, mapped(s_axi_araddr) ? rd_mux : 8'h00};
               rresp_q <= mapped(s_axi_araddr) ? ssi_pkg::RESP_OKAY : ssi_pkg::RESP_SLVERR;
               rd_st_q <= ssi_pkg::BUS_RESP;
            end
            ssi_pkg::BUS_RESP: if (s_axi_rready) begin
               rvalid_q <= 1'b0;
               rd_st_q <= ssi_pkg::BUS_IDLE;
            end
            default: rd_st_q <= ssi_pkg::BUS_IDLE;
         endcase
      end
   end

   // Control registers.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         char9_q <= ssi_pkg::RST_CTRL_BIT;
         txe_ie_q <= ssi_pkg::RST_CTRL_BIT;
         tc_ie_q <= ssi_pkg::RST_CTRL_BIT;
         rxf_ie_q <= ssi_pkg::RST_CTRL_BIT;
         idle_ie_q <= ssi_pkg::RST_CTRL_BIT;
         tx_en_q <= ssi_pkg::RST_CTRL_BIT;
         rx_en_q <= ssi_pkg::RST_CTRL_BIT;
         t8_q <= ssi_pkg::RST_CTRL_BIT;
         err_ie_q <= {4{ssi_pkg::RST_CTRL_BIT}};
      end else if (ce) begin
         if (wr_ctrl1) begin
            char9_q <= s_axi_wdata[ssi_pkg::CTRL1_CHAR9];
         end
         if (wr_ctrl2) begin
            txe_ie_q <= s_axi_wdata[ssi_pkg::CTRL2_TXE_IE];
            tc_ie_q <= s_axi_wdata[ssi_pkg::CTRL2_TC_IE];
            rxf_ie_q <= s_axi_wdata[ssi_pkg::CTRL2_RXF_IE];
            idle_ie_q <= s_axi_wdata[ssi_pkg::CTRL2_IDLE_IE];
            tx_en_q <= s_axi_wdata[ssi_pkg::CTRL2_TX_EN];
            rx_en_q <= s_axi_wdata[ssi_pkg::CTRL2_RX_EN];
         end
         if (wr_ctrl3) begin
            t8_q <= s_axi_wdata[ssi_pkg::CTRL3_T8];
            err_ie_q <= s_axi_wdata[ssi_pkg::CTRL3_OVR_IE:ssi_pkg::CTRL3_PE_IE];
         end
      end
   end

   // Received data and its ninth bit are not reset, so they read unknown until loaded.
   always_ff @(posedge clk_sys) begin
      if (ce && rx_load) begin
         rdr_q <= rx_char.data[7:0];
         r8_q <= char9_q ? rx_char.data[8] : rx_char.data[7];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (ce && wr_data) begin
         tdr_q <= s_axi_wdata[7:0];
      end
   end

   // The word follows the data and ninth bit with one cycle of lag, so the shifter
   // sees a consistent pair when it takes the word.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_word_q <= 9'h0;
      end else if (ce) begin
         tx_word_q <= {char9_q & t8_q, tdr_q};
      end
   end

   // A status read records which flags it saw; a later data access clears only those.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         snap_q <= ssi_pkg::RST_SNAP;
      end else if (ce) begin
         if (rd_status) begin
            snap_q <= status;
         end else begin
            if (rd_data) begin
               snap_q[ssi_pkg::ST_IDLE:ssi_pkg::ST_PE] <= 5'h00;
               snap_q[ssi_pkg::ST_RXF] <= 1'b0;
            end
            if (wr_data) begin
               snap_q[ssi_pkg::ST_TXE] <= 1'b0;
            end
         end
      end
   end

   // Transmitter flags; for the empty flag a set in the same cycle as a clear wins, for the complete flag the clear wins.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_empty_q <= ssi_pkg::RST_TXE;
         tc_q <= ssi_pkg::RST_TC;
      end else if (ce) begin
         if (tx_take && !tx_empty_q) begin
            tx_empty_q <= 1'b1;
         end else if (wr_data && snap_q[ssi_pkg::ST_TXE]) begin
            tx_empty_q <= 1'b0;
         end
         if ((wr_data && snap_q[ssi_pkg::ST_TXE]) || tx_queue || !tx_empty_q) begin
            tc_q <= 1'b0;
         end else if (!tx_busy) begin
            tc_q <= 1'b1;
         end
      end
   end

   // Receiver flags; each clears on a data read only if the last status read saw it set.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rxf_q <= ssi_pkg::RST_FLAG;
         ovr_q <= ssi_pkg::RST_FLAG;
         nf_q <= ssi_pkg::RST_FLAG;
         fe_q <= ssi_pkg::RST_FLAG;
         pe_q <= ssi_pkg::RST_FLAG;
      end else if (ce) begin
         if (rx_load) begin
            rxf_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_RXF]) begin
            rxf_q <= 1'b0;
         end
         if (rx_ovr) begin
            ovr_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_OVR]) begin
            ovr_q <= 1'b0;
         end
         if (rx_load && rx_char.noise) begin
            nf_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_NF]) begin
            nf_q <= 1'b0;
         end
         if (rx_load && rx_char.framing) begin
            fe_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_FE]) begin
            fe_q <= 1'b0;
         end
         if (rx_load && rx_char.parity) begin
            pe_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_PE]) begin
            pe_q <= 1'b0;
         end
      end
   end

   ssi_idle_det u_idle (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .en(rx_en_q),
      .char9(char9_q),
      .bit_tick(rx_bit_tick),
      .line(rx_line),
      .det(idle_det)
   );

   // Idle may only be flagged once a character has arrived since enable or clear.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         idle_arm_q <= ssi_pkg::RST_FLAG;
         idle_q <= ssi_pkg::RST_FLAG;
      end else if (ce) begin
         if (rx_load) begin
            idle_arm_q <= 1'b1;
         end else if ((wr_ctrl2 && !rx_en_q && s_axi_wdata[ssi_pkg::CTRL2_RX_EN]) ||
                      (rd_data && snap_q[ssi_pkg::ST_IDLE])) begin
            idle_arm_q <= 1'b0;
         end
         if (idle_det && idle_arm_q) begin
            idle_q <= 1'b1;
         end else if (rd_data && snap_q[ssi_pkg::ST_IDLE]) begin
            idle_q <= 1'b0;
         end
      end
   end

   // Requests are registered and follow their flags and enables by one cycle.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_q <= '0;
      end else if (ce) begin
         irq_q.tx <= (tx_empty_q && txe_ie_q) || (tc_q && tc_ie_q);
         irq_q.rx <= (rxf_q && rxf_ie_q) || (idle_q && idle_ie_q);
         irq_q.err <= |({ovr_q, nf_q, fe_q, pe_q} & err_ie_q);
      end
   end
endmodule : ssi_top

// ===== tb/ssi_node.sv
// Behavioural model of the remote node and shift registers beside the status block.
`timescale 1ns/1ps
module ssi_node (
   // Clock, reset and bench commands
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic send_go,
   input wire ssi_pkg::ssi_rx_char_t send_val,
   input wire logic line_hi,
   input wire logic queue_go,
   // Block side
   input wire logic [8:0] tx_word_q,
   input wire logic tx_empty_q,
   output logic rx_char_done = 1'b0,
   output ssi_pkg::ssi_rx_char_t rx_char = 12'h000,
   output logic rx_bit_tick = 1'b0,
   output logic rx_line = 1'b1,
   output logic tx_take = 1'b0,
   output logic tx_busy,
   output logic tx_queue = 1'b0,
   output logic [8:0] got_word = 9'h000
);
   logic [1:0] div_q = 2'h0;
   logic [1:0] lag_q = 2'h0;
   logic [3:0] cnt_q = 4'h0;
   assign tx_busy = cnt_q != 4'h0;
   always @(posedge clk_sys) begin
      div_q <= rst ? 2'h0 : div_q + 2'h1;
      rx_bit_tick <= !rst && div_q == 2'h3;
      rx_line <= line_hi;
      rx_char_done <= send_go;
      // Outside its strobe the character is scrambled, so no stale value can pass for a new one.
      rx_char <= send_go ? send_val : ~rx_char;
      tx_queue <= queue_go;
      tx_take <= 1'b0;
      if (rst) begin
         cnt_q <= 4'h0;
         lag_q <= 2'h0;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end else if (!tx_empty_q && !tx_take) begin
         // A slow shifter: the word is taken four cycles after it is offered.
         lag_q <= lag_q + 2'h1;
         if (lag_q == 2'h3) begin
            tx_take <= 1'b1;
            got_word <= tx_word_q;
            cnt_q <= 4'hc;
         end
      end else begin
         lag_q <= 2'h0;
      end
   end
endmodule : ssi_node

// ===== tb/ssi_chk.sv
// Port checker of the serial status block.
`timescale 1ns/1ps
module ssi_chk (
   // Clock, reset and clock enable
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Transmit side and requests
   input wire logic tx_take,
   input wire logic [8:0] tx_word_q,
   input wire logic tx_empty_q,
   input wire ssi_pkg::ssi_irq_t irq_q
);
   // Shadow enables, taken at the same edge as the block takes the write.
   logic [3:0] ie2_q;
   logic [3:0] ie3_q;
   logic hit;
   assign hit = ce && s_axi_awvalid && s_axi_awready && s_axi_wstrb[0];
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ie2_q <= 4'h0;
         ie3_q <= 4'h0;
      end else if (hit) begin
         if (s_axi_awaddr == {24'h000000, ssi_pkg::IDX_CTRL2, 2'h0}) ie2_q <= s_axi_wdata[7:4];
         if (s_axi_awaddr == {24'h000000, ssi_pkg::IDX_CTRL3, 2'h0}) ie3_q <= s_axi_wdata[3:0];
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_reset;
      disable iff (1'b0) rst |=> tx_empty_q && tx_word_q == 9'h000 && !irq_q.tx;
   endproperty
   property p_take;
      ce && tx_take && !tx_empty_q |=> tx_empty_q;
   endproperty
   property p_txirq;
      tx_empty_q && ie2_q[3] |=> irq_q.tx;
   endproperty
   property p_txoff;
      ie2_q[3:2] == 2'h0 |=> !irq_q.tx;
   endproperty
   property p_rxoff;
      ie2_q[1:0] == 2'h0 |=> !irq_q.rx;
   endproperty
   property p_erroff;
      ie3_q == 4'h0 |=> !irq_q.err;
   endproperty
   property p_bresp;
      s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
   endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   a_take: assert property (p_take) else $error("empty not set on take");
   a_txirq: assert property (p_txirq) else $error("tx request missing");
   a_txoff: assert property (p_txoff) else $error("tx request unmasked");
   a_rxoff: assert property (p_rxoff) else $error("rx request unmasked");
   a_erroff: assert property (p_erroff) else $error("error request unmasked");
   a_bresp: assert property (p_bresp) else $error("write response late");
   a_rhold: assert property (p_rhold) else $error("read data not held");
   c_take: cover property (tx_take);
   c_err: cover property (irq_q.err);
   c_rx: cover property (irq_q.rx);
endmodule : ssi_chk

bind ssi_top ssi_chk ssi_chk_i (.*);

// ===== tb/test_serial_status_and_error_irq.sv
// Self-checking bench of the serial status block with the remote node model.
`timescale 1ns/1ps
module test_serial_status_and_error_irq;
   typedef struct {
      logic wr;
      logic [31:0] a;
      logic [7:0] d, e, m;
      logic [1:0] r;
   } ssi_row_t;
   localparam logic [31:0] A_C1 = {24'h000000, ssi_pkg::IDX_CTRL1, 2'h0};
   localparam logic [31:0] A_C2 = {24'h000000, ssi_pkg::IDX_CTRL2, 2'h0};
   localparam logic [31:0] A_C3 = {24'h000000, ssi_pkg::IDX_CTRL3, 2'h0};
   localparam logic [31:0] A_ST = {24'h000000, ssi_pkg::IDX_STATUS, 2'h0};
   localparam logic [31:0] A_DT = {24'h000000, ssi_pkg::IDX_DATA, 2'h0};
   logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic rx_char_done, rx_bit_tick, rx_line, tx_take, tx_busy, tx_queue, tx_empty_q;
   logic char9_q, tx_en_q, rx_en_q;
   logic send_go = 1'b0, line_hi = 1'b1, queue_go = 1'b0;
   logic [8:0] tx_word_q, got_word;
   logic [7:0] d;
   ssi_pkg::ssi_rx_char_t rx_char, send_val = 12'h000;
   ssi_pkg::ssi_irq_t irq_q;
   wire logic [3:0] hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
   int err_total = 0, checked = 0;
   ssi_row_t rows [5] = '{
      '{1'b0, A_ST, 8'h00, 8'hc0, 8'hff, ssi_pkg::RESP_OKAY},
      '{1'b0, A_C3, 8'h00, 8'h00, 8'h7f, ssi_pkg::RESP_OKAY},
      '{1'b1, A_C3, 8'h4f, 8'h4f, 8'h7f, ssi_pkg::RESP_OKAY},
      '{1'b1, A_C2, 8'hfc, 8'hfc, 8'hff, ssi_pkg::RESP_OKAY},
      '{1'b1, 32'h00000040, 8'h5a, 8'h00, 8'hff, ssi_pkg::RESP_SLVERR}};

   ssi_top ssi_top_i (.*);
   ssi_node ssi_node_i (.*);

   always #2.5 clk_sys = ~clk_sys;

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, s);
         err_total++;
      end
   endtask : chk

   // Waits for one handshake bit; a hang counts as a mismatch and ends the run.
   task automatic wt(input int k);
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hs[k] !== 1'b1) begin
         n++;
         if (n > 200) begin
            err_total++;
            stop_test();
         end
         @(posedge clk_sys);
      end
   endtask : wt

   task automatic wr(input logic [31:0] a, input logic [7:0] v, output logic [1:0] rs);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      wt(0);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wt(1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [7:0] v, output logic [1:0] rs);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      s_axi_araddr <= a;
      wt(2);
      s_axi_arvalid <= 1'b0;
      wt(3);
      v = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask : rd

   task automatic send(input logic [8:0] v, input logic [2:0] f);
      send_val <= {v, f};
      send_go <= 1'b1;
      @(posedge clk_sys);
      send_go <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : send

   task automatic wait_idle;
      repeat (60) @(posedge clk_sys);
      rd(A_ST, d, r);
   endtask : wait_idle

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      wr(A_DT, 8'h00, r);
      chk("txe_unrecorded", 1, tx_empty_q);
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d, r);
         if (rows[i].wr) chk("wr_resp", rows[i].r, r);
         rd(rows[i].a, d, r);
         chk("rd_resp", rows[i].r, r);
         chk("rd_value", rows[i].e, d & rows[i].m);
      end
      chk("irq_tx", 1, irq_q.tx);
      wait_idle();
      chk("idle_nochar", 0, d & 8'h10);
      $display("test registers done");
      line_hi <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         wr(A_C1, i ? 8'h00 : 8'h10, r);
         send(i ? 9'h080 : 9'h17f, 3'h0);
         chk("irq_rx", 1, irq_q.rx);
         rd(A_C3, d, r);
         chk("rx_ninth", 8'h80, d & 8'h80);
         rd(A_ST, d, r);
         chk("rx_full", 8'h20, d & 8'h20);
         rd(A_DT, d, r);
         chk("rx_data", i ? 8'h80 : 8'h7f, d);
         rd(A_ST, d, r);
         chk("rx_full_clr", 0, d & 8'h20);
      end
      line_hi <= 1'b1;
      wait_idle();
      chk("idle_set", 8'h10, d & 8'h10);
      chk("irq_idle", 1, irq_q.rx);
      rd(A_DT, d, r);
      wait_idle();
      chk("idle_clr", 0, d & 8'h10);
      $display("test receive done");
      for (int i = 0; i < 3; i++) begin
         send(9'h0d5, 3'h4 >> i);
         chk("irq_err", 1, irq_q.err);
         rd(A_ST, d, r);
         chk("err_flag", 8'h04 >> i, d & 8'h0f);
         rd(A_DT, d, r);
         rd(A_ST, d, r);
         chk("err_clr", 0, d & 8'h0f);
      end
      send(9'h091, 3'h0);
      rd(A_ST, d, r);
      send(9'h022, 3'h0);
      chk("irq_ovr", 1, irq_q.err);
      rd(A_DT, d, r);
      chk("ovr_data", 8'h91, d);
      rd(A_ST, d, r);
      chk("ovr_kept", 8'h08, d & 8'h28);
      rd(A_DT, d, r);
      rd(A_ST, d, r);
      chk("ovr_clr", 0, d & 8'h08);
      $display("test errors done");
      wr(A_C1, 8'h10, r);
      rd(A_ST, d, r);
      wr(A_DT, 8'h3c, r);
      rd(A_ST, d, r);
      chk("tc_busy", 0, d & 8'h40);
      repeat (30) @(posedge clk_sys);
      chk("tx_word", 9'h13c, got_word);
      rd(A_ST, d, r);
      chk("tc_idle", 8'hc0, d & 8'hc0);
      queue_go <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(A_ST, d, r);
      chk("tc_queued", 0, d & 8'h40);
      queue_go <= 1'b0;
      $display("test transmit done");
      // A character offered while the clock enable is low must leave no trace.
      ce <= 1'b0;
      send(9'h055, 3'h7);
      chk("ce_irq_err", 0, irq_q.err);
      ce <= 1'b1;
      @(posedge clk_sys);
      rd(A_ST, d, r);
      chk("ce_frozen", 0, d & 8'h2f);
      $display("test clock enable done");
      wr(A_C1, 8'h00, r);
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      rd(A_C3, d, r);
      chk("ctrl3_rst", 8'h80, d);
      $display("test reset done");
      stop_test();
   end
endmodule : test_serial_status_and_error_irq
